// ===== include/dpd_pkg.sv
// constants for the dual channel pwm dac
package dpd_pkg;
   localparam logic [4:0] DPD_ADDR_DUTY0 = 5'h04;
   localparam logic [4:0] DPD_ADDR_DUTY1 = 5'h05;
   localparam logic [4:0] DPD_ADDR_MODE = 5'h13;
   localparam int DPD_SEL0_BIT = 0;
   localparam int DPD_SEL1_BIT = 1;
   localparam logic [3:0] DPD_MODE_RESET = 4'h0;
   localparam logic [7:0] DPD_DUTY_RESET = 8'h00;
   localparam int DPD_CORE_HZ = 100000000;
   localparam int DPD_BASE_HZ = 1125000;
   // shorter period: divider rounds down to 88
   localparam int DPD_BASE_DIV = DPD_CORE_HZ / DPD_BASE_HZ;
   // quarter count offset of the high time
   localparam int DPD_QUARTER = DPD_BASE_DIV / 4;
   // channel b base clock leads channel a by half a base period
   localparam int DPD_PHASE_B = DPD_BASE_DIV / 2;
endpackage

// ===== hdl/dpd_channel.sv
// one pwm channel: base clock divider, 8-bit counter, comparator
`timescale 1ns/1ns
`default_nettype none
module dpd_channel
   import dpd_pkg::*;
#(
   parameter int DIV = DPD_BASE_DIV,
   parameter int PHASE = 0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // duty
   input wire logic [7:0] duty,
   // waveform
   output logic pwm_out
);
   logic [7:0] div_reg;
   logic [7:0] count_reg;
   logic base_tick;

   assign base_tick = (div_reg == 8'(DIV - 1));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 8'(PHASE);
      end else if (base_tick) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // free running 8-bit counter of base clocks
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 8'h00;
      end else if (base_tick) begin
         count_reg <= count_reg + 8'h01; // [RULE7] [RULE9]
      end
   end

   // high while duty > count, plus a quarter count so x=0 still pulses
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (duty > count_reg) ||
            (duty == count_reg && div_reg < 8'(DPD_QUARTER)); // [RULE7] [RULE8]
      end
   end

   a_duty_compare: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
      (duty > count_reg) && $stable(duty) |=> pwm_out)
      else $error("output low while duty exceeds count");
   a_duty_low: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
      (duty < count_reg) && $stable(duty) |=> !pwm_out)
      else $error("output high while duty below count");
   a_period_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
      base_tick && count_reg == 8'hFF |=> count_reg == 8'h00)
      else $error("counter does not wrap at 256");
   a_zero_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE8]
      duty == 8'h00 && count_reg == 8'h00 && div_reg == 8'h00 && $stable(duty) |=> pwm_out)
      else $error("no short pulse at zero duty");
endmodule
`default_nettype wire

// ===== hdl/dpd_top.sv
// dual channel pwm dac with peripheral register port
// Behaviour
// [RULE1] each pin has its own select flag
// [RULE2] flag 0 port, flag 1 pwm
// [RULE3] 4-bit mode register, upper bits read zero
// [RULE4] mode clears on power-on and clock-stop
// [RULE5] 1.125 MHz base clock per channel (code: 100 MHz core clock divided by 88, about 1.136 MHz)
// [RULE6] channel b base clock phase offset
// [RULE7] 8-bit counter, high while duty above count
// [RULE8] high fraction is (x+0.25)/256
// [RULE9] period is 256 base counts
// [RULE10] duty registers at 04H and 05H
// [RULE11] duty from two low buffer nibbles
// [RULE12] software loads duty before select
// [RULE13] software avoids duty rewrite while running
// [RULE14] power-on: port mode, duty undefined
// [RULE15] clock-stop: port mode, duty kept
// [RULE16] ce reset and halt keep pin state
`timescale 1ns/1ns
`default_nettype none
module dpd_top
   import dpd_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // device state events
   input wire logic clock_stop,
   input wire logic ce_reset,
   input wire logic halt,
   // peripheral register port, transfer from the data buffer
   input wire logic [4:0] periph_addr,
   input wire logic periph_wr,
   input wire logic periph_rd,
   input wire logic [15:0] transfer_buffer,
   output logic [15:0] periph_rdata,
   // general purpose port latches
   input wire logic port_latch_a,
   input wire logic port_latch_b,
   // open-drain pins, enable low while driving low
   output logic duty_output_a_out,
   output logic duty_output_a_oe_n,
   output logic duty_output_b_out,
   output logic duty_output_b_oe_n
);
   logic rst_meta_reg;
   logic rst_n_reg;
   logic [1:0] mode_reg;
   logic [7:0] chan0_duty_reg;
   logic [7:0] chan1_duty_reg;
   logic wave_a;
   logic wave_b;
   logic level_a;
   logic level_b;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
      hit = (a == target);
   endfunction

   // ce reset does not touch the select flags
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         mode_reg <= DPD_MODE_RESET[1:0]; // [RULE4] [RULE14]
      end else if (clock_stop) begin
         mode_reg <= DPD_MODE_RESET[1:0]; // [RULE4] [RULE15]
      end else if (periph_wr && hit(periph_addr, DPD_ADDR_MODE)) begin
         mode_reg <= transfer_buffer[1:0]; // [RULE1] [RULE3]
      end
   end

   // undefined after power-on; reset to zero for determinism, kept on clock-stop
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         chan0_duty_reg <= DPD_DUTY_RESET;
         chan1_duty_reg <= DPD_DUTY_RESET;
      end else if (periph_wr) begin
         if (hit(periph_addr, DPD_ADDR_DUTY0)) begin
            chan0_duty_reg <= transfer_buffer[7:0]; // [RULE10] [RULE11]
         end
         if (hit(periph_addr, DPD_ADDR_DUTY1)) begin
            chan1_duty_reg <= transfer_buffer[7:0]; // [RULE10] [RULE11]
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         periph_rdata <= 16'h0000;
      end else if (periph_rd) begin
         if (hit(periph_addr, DPD_ADDR_MODE)) begin
            periph_rdata <= {14'h0000, mode_reg}; // [RULE3]
         end else if (hit(periph_addr, DPD_ADDR_DUTY0)) begin
            periph_rdata <= {8'h00, chan0_duty_reg};
         end else if (hit(periph_addr, DPD_ADDR_DUTY1)) begin
            periph_rdata <= {8'h00, chan1_duty_reg};
         end else begin
            periph_rdata <= 16'h0000;
         end
      end
   end

   // channels keep running in halt and ce reset
   dpd_channel #(.DIV(DPD_BASE_DIV), .PHASE(0)) u_chan_a (
      .core_clk(core_clk),
      .rst_n(rst_n_reg),
      .duty(chan0_duty_reg),
      .pwm_out(wave_a)
   ); // [RULE5]
   dpd_channel #(.DIV(DPD_BASE_DIV), .PHASE(DPD_PHASE_B)) u_chan_b (
      .core_clk(core_clk),
      .rst_n(rst_n_reg),
      .duty(chan1_duty_reg),
      .pwm_out(wave_b)
   ); // [RULE5] [RULE6]

   assign level_a = mode_reg[DPD_SEL0_BIT] ? wave_a : port_latch_a; // [RULE2]
   assign level_b = mode_reg[DPD_SEL1_BIT] ? wave_b : port_latch_b; // [RULE2]

   // pin a open drain: drive low, release for high; halt/ce_reset change nothing
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         duty_output_a_out <= 1'b0;
         duty_output_a_oe_n <= 1'b1; // [RULE14]
      end else begin
         duty_output_a_out <= 1'b0;
         duty_output_a_oe_n <= level_a; // [RULE16]
      end
   end

   // pin b: same drive, released at power-on since the level is undefined
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         duty_output_b_out <= 1'b0;
         duty_output_b_oe_n <= 1'b1; // [RULE14]
      end else begin
         duty_output_b_out <= 1'b0;
         duty_output_b_oe_n <= level_b; // [RULE16]
      end
   end

   // select flags: clock stop beats a write in the same cycle
   a_stop_clears: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE4]
      clock_stop |=> mode_reg == 2'b00)
      else $error("clock stop did not clear select flags");

   a_ce_keeps: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE4]
      (ce_reset || halt) && !clock_stop && !periph_wr |=> $stable(mode_reg))
      else $error("ce reset or halt changed select flags");

   a_mode_write: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE1]
      periph_wr && periph_addr == DPD_ADDR_MODE && !clock_stop |=> mode_reg == $past(transfer_buffer[1:0]))
      else $error("select flags not taken from write data");

   a_mode_other: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE3]
      periph_wr && periph_addr != DPD_ADDR_MODE && !clock_stop |=> $stable(mode_reg))
      else $error("write elsewhere changed select flags");

   // duty registers
   a_duty_write: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE11]
      periph_wr && periph_addr == DPD_ADDR_DUTY1 |=> chan1_duty_reg == $past(transfer_buffer[7:0]))
      else $error("duty not taken from low nibbles");

   a_duty0_write: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE10]
      periph_wr && periph_addr == DPD_ADDR_DUTY0 |=> chan0_duty_reg == $past(transfer_buffer[7:0]))
      else $error("channel a duty not written");

   a_duty_hold: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE10]
      !periph_wr |=> $stable(chan0_duty_reg) && $stable(chan1_duty_reg))
      else $error("duty changed without a write");

   a_stop_duty: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE15]
      clock_stop && !periph_wr |=> $stable(chan0_duty_reg) && $stable(chan1_duty_reg))
      else $error("clock stop lost duty");

   // read port
   a_read_mode: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE3]
      periph_rd && periph_addr == DPD_ADDR_MODE |=> periph_rdata == {14'h0000, $past(mode_reg)})
      else $error("mode read wrong");

   a_read_duty0: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE10]
      periph_rd && periph_addr == DPD_ADDR_DUTY0 |=> periph_rdata == {8'h00, $past(chan0_duty_reg)})
      else $error("channel a duty read wrong");

   a_read_duty1: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE10]
      periph_rd && periph_addr == DPD_ADDR_DUTY1 |=> periph_rdata == {8'h00, $past(chan1_duty_reg)})
      else $error("channel b duty read wrong");

   a_read_other: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE3]
      periph_rd && periph_addr != DPD_ADDR_MODE && periph_addr != DPD_ADDR_DUTY0 &&
      periph_addr != DPD_ADDR_DUTY1 |=> periph_rdata == 16'h0000)
      else $error("unmapped read not zero");

   a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE3]
      !periph_rd |=> $stable(periph_rdata))
      else $error("read data changed without a read");

   // pins, one cycle behind the selected level
   a_port_mode: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE2]
      !mode_reg[DPD_SEL0_BIT] |=> duty_output_a_oe_n == $past(port_latch_a))
      else $error("port mode pin does not follow latch");

   a_port_mode_b: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE2]
      !mode_reg[DPD_SEL1_BIT] |=> duty_output_b_oe_n == $past(port_latch_b))
      else $error("port mode pin b does not follow latch");

   a_pwm_mode: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE2]
      mode_reg[DPD_SEL1_BIT] |=> duty_output_b_oe_n == $past(wave_b))
      else $error("pwm mode pin does not follow waveform");

   a_pwm_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE2]
      mode_reg[DPD_SEL0_BIT] |=> duty_output_a_oe_n == $past(wave_a))
      else $error("pwm mode pin a does not follow waveform");

   a_stop_port: assert property (@(posedge core_clk) disable iff (!rst_n_reg) // [RULE15]
      clock_stop |=> ##1 duty_output_a_oe_n == $past(port_latch_a) && duty_output_b_oe_n == $past(port_latch_b))
      else $error("clock stop did not return pins to port latches");
endmodule
`default_nettype wire

// ===== test/dpd_pullup_filter.sv
// pull-up resistor and averaging filter model on one open-drain pin
`timescale 1ns/1ns
`default_nettype none
module dpd_pullup_filter (
   // clock
   input wire logic core_clk,
   // pin drive from the block
   input wire logic pin_out,
   input wire logic pin_oe_n,
   // averaging window and result
   input wire logic meas,
   output logic pin_level,
   output logic [15:0] high_cnt
);
   // a released pin is pulled up, never left floating
   assign pin_level = pin_oe_n ? 1'b1 : pin_out;
   always @(posedge core_clk) begin
      if (!meas)
         high_cnt <= 16'h0000;
      else if (pin_level)
         high_cnt <= high_cnt + 16'h0001;
   end
endmodule
`default_nettype wire

// ===== test/tb_dpd_top.sv
// self-checking bench for the dual channel pwm dac
`timescale 1ns/1ns
`default_nettype none
module tb_dpd_top
   import dpd_pkg::*;
;
   logic core_clk = 0, nrst = 0, clock_stop = 0, ce_reset = 0, halt = 0, meas = 0;
   logic periph_wr = 0, periph_rd = 0, port_latch_a = 0, port_latch_b = 0;
   logic [4:0] periph_addr = 5'h00;
   logic [15:0] transfer_buffer = 16'h0000;
   logic [15:0] periph_rdata, rd_val, cnt_a, cnt_b;
   logic oa, oea, ob, oeb, pin_a, pin_b;
   int n_mismatch = 0, tests_run = 0;
   // address, write data, expected read back
   logic [36:0] rows [5] = '{{5'h13, 16'hFFFF, 16'h0003}, {5'h04, 16'hAB55, 16'h0055},
      {5'h05, 16'h12C3, 16'h00C3}, {5'h1F, 16'hFFFF, 16'h0000}, {5'h13, 16'h0000, 16'h0000}};
   always #5 core_clk = ~core_clk;
   dpd_top u_dpd_top (.core_clk(core_clk), .nrst(nrst), .clock_stop(clock_stop), .ce_reset(ce_reset),
      .halt(halt), .periph_addr(periph_addr), .periph_wr(periph_wr), .periph_rd(periph_rd),
      .transfer_buffer(transfer_buffer), .periph_rdata(periph_rdata), .port_latch_a(port_latch_a),
      .port_latch_b(port_latch_b), .duty_output_a_out(oa), .duty_output_a_oe_n(oea),
      .duty_output_b_out(ob), .duty_output_b_oe_n(oeb));
   dpd_pullup_filter u_dpd_pullup_filter_a (.core_clk(core_clk), .pin_out(oa), .pin_oe_n(oea),
      .meas(meas), .pin_level(pin_a), .high_cnt(cnt_a));
   dpd_pullup_filter u_dpd_pullup_filter_b (.core_clk(core_clk), .pin_out(ob), .pin_oe_n(oeb),
      .meas(meas), .pin_level(pin_b), .high_cnt(cnt_b));
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk);
      periph_addr <= a;
      transfer_buffer <= d;
      periph_wr <= 1'b1;
      @(posedge core_clk);
      periph_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge core_clk);
      periph_addr <= a;
      periph_rd <= 1'b1;
      @(posedge core_clk);
      periph_rd <= 1'b0;
      @(posedge core_clk);
      rd_val = periph_rdata;
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // watchdog against a hung run
   initial begin
      #900000;
      n_mismatch++;
      summarize;
   end
   initial begin
      wt(2);
      nrst <= 1'b1;
      wt(3);
      rd(DPD_ADDR_MODE);
      chk(rd_val, {12'h000, DPD_MODE_RESET});
      for (int i = 0; i < 5; i++) begin
         wr(rows[i][36:32], rows[i][31:16]);
         rd(rows[i][36:32]);
         chk(rd_val, rows[i][15:0]);
      end
      port_latch_a <= 1'b1;
      wt(3);
      chk({14'h0000, pin_a, pin_b}, 16'h0002);
      // duty loaded before select, never rewritten while running
      wr(DPD_ADDR_DUTY0, 16'hF000);
      wr(DPD_ADDR_DUTY1, 16'h00FF);
      wr(DPD_ADDR_MODE, 16'h0003);
      halt <= 1'b1;
      ce_reset <= 1'b1;
      wt(4);
      meas <= 1'b1;
      wt(256 * DPD_BASE_DIV);
      meas <= 1'b0;
      #1;
      chk(cnt_a, 16'(DPD_QUARTER));
      chk(cnt_b, 16'(255 * DPD_BASE_DIV + DPD_QUARTER));
      wt(1);
      halt <= 1'b0;
      ce_reset <= 1'b0;
      rd(DPD_ADDR_MODE);
      chk(rd_val, 16'h0003);
      // pin a back to port with its latch high; a stuck flag would show the near-zero wave
      wr(DPD_ADDR_MODE, 16'h0002);
      wt(3);
      chk({15'h0000, pin_a}, 16'h0001);
      port_latch_a <= 1'b0;
      port_latch_b <= 1'b0;
      clock_stop <= 1'b1;
      wt(1);
      clock_stop <= 1'b0;
      wt(3);
      chk({14'h0000, pin_a, pin_b}, 16'h0000);
      chk({14'h0000, oa, ob}, 16'h0000);
      rd(DPD_ADDR_MODE);
      chk(rd_val, 16'h0000);
      rd(DPD_ADDR_DUTY1);
      chk(rd_val, 16'h00FF);
      // reset in mid-run: both pins in pwm mode before, released during
      wr(DPD_ADDR_MODE, 16'h0003);
      wt(1);
      nrst <= 1'b0;
      wt(2);
      chk({14'h0000, oea, oeb}, 16'h0003);
      nrst <= 1'b1;
      wt(3);
      rd(DPD_ADDR_MODE);
      chk(rd_val, 16'h0000);
      summarize;
   end
endmodule
`default_nettype wire
